// >>> rtl/fsp_ctrl.v
// Flash self-programming sequencer: command register, page buffer, timing
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "fsp_consts.vh"

module fsp_ctrl #(
    parameter [15:0] BOOT_VECTOR = 16'h3800,
    parameter [9:0] HALT_FIRST_PAGE = 10'h1C0,
    parameter integer PROG_CYCLES = (`FSP_PROG_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [7:0] rdata_o,
    // CPU instruction strobes
    input wire store_i,
    input wire load_i,
    output wire [7:0] load_data_o,
    output wire cpu_halt_o,
    output wire irq_o,
    // EEPROM status
    input wire eeprom_write_busy_i,
    // Boot fuse pin
    input wire boot_vector_fuse_i,
    output wire [15:0] reset_vector_o,
    // Flash array
    output wire [14:0] fl_read_addr_o,
    input wire [15:0] fl_read_word_i,
    output wire fl_erase_o,
    output wire fl_write_o,
    output wire [9:0] fl_page_o,
    input wire [4:0] fl_buf_idx_i,
    output wire [15:0] fl_buf_data_o,
    output wire section_block_o,
    output wire [5:0] lock_bits_o
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ARMED = 2'b01;
    localparam [1:0] ST_PROG = 2'b10;

    localparam [1:0] OP_ERASE = 2'b00;
    localparam [1:0] OP_WRITE = 2'b01;
    localparam [1:0] OP_LOCK = 2'b10;

    // Count fits 19 bits for the full programming time; the slice drops no bits
    localparam integer PROG_LAST_I = PROG_CYCLES - 1;
    localparam [18:0] PROG_LAST = PROG_LAST_I[18:0];

    function in_halting;
        input [9:0] page;
        begin
            in_halting = (page >= HALT_FIRST_PAGE);
        end
    endfunction

    function wr_at;
        input [7:0] adr;
        input [7:0] sel;
        input we;
        begin
            wr_at = we && (adr == sel);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Fuse pin synchroniser and reset vector

    reg fuse_meta_r;
    reg fuse_sync_r;
    reg [15:0] vector_r;

    always @(posedge clk_i) begin
        fuse_meta_r <= boot_vector_fuse_i;
        fuse_sync_r <= fuse_meta_r;
    end

    // Fuse is only sampled; nothing here can alter it
    always @(posedge clk_i) begin
        if (rst_i) begin
            vector_r <= `FSP_APP_VECTOR;
        end else begin
            vector_r <= fuse_sync_r ? `FSP_APP_VECTOR : BOOT_VECTOR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    reg [7:0] ptr_lo_r;
    reg [7:0] ptr_hi_r;
    reg [7:0] dat_lo_r;
    reg [7:0] dat_hi_r;
    reg [7:0] cmd_r;
    reg [7:0] cmd_nxt;
    reg inten_r;
    reg busy_flag_r;
    reg [1:0] state_r;
    reg [1:0] op_r;
    reg [2:0] arm_cnt_r;
    reg [18:0] prog_cnt_r;
    reg [9:0] page_r;
    reg halting_r;
    reg [7:0] lock_data_r;
    reg [5:0] lock_bits_r;
    reg [7:0] rdata_r;

    wire [15:0] ptr = {ptr_hi_r, ptr_lo_r};
    wire cmd_wr = wr_at(addr_i, `FSP_ADR_CMD, wr_i);
    wire [7:0] cmd_code = wdata_i & `FSP_CODE_MASK;
    // Commands are refused while EEPROM is writing; the interrupt-enable bit is still written
    wire cmd_accept = cmd_wr && !eeprom_write_busy_i && (state_r == ST_IDLE);
    wire reen_wr = cmd_accept && (cmd_code == `FSP_CODE_REEN);
    wire fire = (state_r == ST_ARMED) && store_i;
    wire [7:0] armed_code = cmd_r & `FSP_CODE_MASK;
    wire prog_done = (state_r == ST_PROG) && (prog_cnt_r == PROG_LAST);

    always @(posedge clk_i) begin
        if (rst_i) begin
            ptr_lo_r <= 8'h00;
            ptr_hi_r <= 8'h00;
            dat_lo_r <= 8'h00;
            dat_hi_r <= 8'h00;
            inten_r <= 1'b0;
        end else begin
            if (wr_at(addr_i, `FSP_ADR_PTR_LO, wr_i)) begin
                ptr_lo_r <= wdata_i;
            end
            if (wr_at(addr_i, `FSP_ADR_PTR_HI, wr_i)) begin
                ptr_hi_r <= wdata_i;
            end
            if (wr_at(addr_i, `FSP_ADR_DAT_LO, wr_i)) begin
                dat_lo_r <= wdata_i;
            end
            if (wr_at(addr_i, `FSP_ADR_DAT_HI, wr_i)) begin
                dat_hi_r <= wdata_i;
            end
            if (cmd_wr) begin
                inten_r <= wdata_i[`FSP_B_INTEN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer

    always @* begin
        cmd_nxt = cmd_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_accept && !reen_wr && cmd_code[`FSP_B_ENABLE]) begin
                    cmd_nxt = cmd_code;
                end
            end
            ST_ARMED: begin
                // Window lapsed or load done: enable drops
                if ((arm_cnt_r == 3'h1 && !store_i) || (fire && armed_code == `FSP_CODE_LOAD)) begin
                    cmd_nxt = `FSP_CMD_RESET;
                end else if (fire && armed_code != `FSP_CODE_ERASE && armed_code != `FSP_CODE_WRITE
                             && armed_code != `FSP_CODE_LOCK) begin
                    cmd_nxt = `FSP_CMD_RESET;
                end
            end
            ST_PROG: begin
                if (prog_done) begin
                    cmd_nxt = `FSP_CMD_RESET;
                end
            end
            default: begin
                cmd_nxt = `FSP_CMD_RESET;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cmd_r <= `FSP_CMD_RESET;
            arm_cnt_r <= 3'h0;
            op_r <= OP_ERASE;
            page_r <= 10'h000;
            halting_r <= 1'b0;
            lock_data_r <= 8'hFF;
            prog_cnt_r <= 19'h00000;
        end else begin
            cmd_r <= cmd_nxt;
            case (state_r)
                ST_IDLE: begin
                    if (cmd_accept && !reen_wr && cmd_code[`FSP_B_ENABLE]) begin
                        state_r <= ST_ARMED;
                        arm_cnt_r <= `FSP_ARM_CYCLES;
                    end
                end
                ST_ARMED: begin
                    arm_cnt_r <= arm_cnt_r - 3'h1;
                    if (fire && (armed_code == `FSP_CODE_ERASE || armed_code == `FSP_CODE_WRITE)) begin
                        state_r <= ST_PROG;
                        op_r <= (armed_code == `FSP_CODE_ERASE) ? OP_ERASE : OP_WRITE;
                        // Page latched; pointer free for other use
                        page_r <= ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
                        halting_r <= in_halting(ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB]);
                        prog_cnt_r <= 19'h00000;
                    end else if (fire && armed_code == `FSP_CODE_LOCK) begin
                        // Pointer not consulted here
                        state_r <= ST_PROG;
                        op_r <= OP_LOCK;
                        lock_data_r <= dat_lo_r;
                        halting_r <= 1'b0;
                        prog_cnt_r <= 19'h00000;
                    end else if (fire || arm_cnt_r == 3'h1) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    prog_cnt_r <= prog_cnt_r + 19'h00001;
                    if (prog_done) begin
                        state_r <= ST_IDLE;
                        halting_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Section busy flag and lock bits

    wire prog_start = fire && (armed_code == `FSP_CODE_ERASE || armed_code == `FSP_CODE_WRITE);

    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_flag_r <= 1'b0;
        end else if (prog_start) begin
            busy_flag_r <= 1'b1;
        end else if (reen_wr && state_r == ST_IDLE) begin
            busy_flag_r <= 1'b0;
        end
    end

    // Lock bits only ever go from one to zero here
    always @(posedge clk_i) begin
        if (rst_i) begin
            lock_bits_r <= `FSP_LOCK_RESET;
        end else if (prog_done && op_r == OP_LOCK) begin
            lock_bits_r <= lock_bits_r & lock_data_r[`FSP_LOCK_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Temporary page buffer

    reg [15:0] buf_mem [0:`FSP_BUF_WORDS-1];
    reg [`FSP_BUF_WORDS-1:0] buf_used_r;
    reg [15:0] buf_out_r;

    wire [4:0] load_slot = ptr[`FSP_WORD_MSB:`FSP_WORD_LSB];
    wire buf_load = fire && (armed_code == `FSP_CODE_LOAD) && !buf_used_r[load_slot];
    wire write_done = prog_done && (op_r == OP_WRITE);
    // Loading counts as in progress once any slot holds data
    wire eeprom_kill = eeprom_write_busy_i && (|buf_used_r);

    always @(posedge clk_i) begin
        if (buf_load) begin
            buf_mem[load_slot] <= {dat_hi_r, dat_lo_r};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            buf_used_r <= {`FSP_BUF_WORDS{1'b0}};
        end else if (write_done || reen_wr || eeprom_kill) begin
            buf_used_r <= {`FSP_BUF_WORDS{1'b0}};
        end else if (buf_load) begin
            buf_used_r[load_slot] <= 1'b1;
        end
    end

    // Cleared slots read as erased flash, so stale words never reach the page
    always @(posedge clk_i) begin
        if (rst_i) begin
            buf_out_r <= `FSP_ERASED_WORD;
        end else begin
            buf_out_r <= buf_used_r[fl_buf_idx_i] ? buf_mem[fl_buf_idx_i] : `FSP_ERASED_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program memory loads

    reg [7:0] load_data_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            load_data_r <= 8'h00;
        end else if (load_i) begin
            load_data_r <= ptr[`FSP_BYTE_SEL] ? fl_read_word_i[15:8] : fl_read_word_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read-back

    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `FSP_ADR_CMD: begin
                    rdata_r <= {inten_r, busy_flag_r, 1'b0, cmd_r[4:0]};
                end
                `FSP_ADR_PTR_LO: begin
                    rdata_r <= ptr_lo_r;
                end
                `FSP_ADR_PTR_HI: begin
                    rdata_r <= ptr_hi_r;
                end
                `FSP_ADR_DAT_LO: begin
                    rdata_r <= dat_lo_r;
                end
                `FSP_ADR_DAT_HI: begin
                    rdata_r <= dat_hi_r;
                end
                `FSP_ADR_STATUS: begin
                    // Lock readback withheld during EEPROM writes
                    rdata_r <= eeprom_write_busy_i ? 8'h00 : {2'b11, lock_bits_r};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    wire prog_busy = (state_r == ST_PROG) && (op_r != OP_LOCK);

    assign rdata_o = rdata_r;
    assign load_data_o = load_data_r;
    assign reset_vector_o = vector_r;
    assign cpu_halt_o = halting_r;
    assign irq_o = inten_r && !cmd_r[`FSP_B_ENABLE];
    assign section_block_o = busy_flag_r;
    assign fl_read_addr_o = ptr[15:1];
    assign fl_erase_o = prog_busy && (op_r == OP_ERASE);
    assign fl_write_o = prog_busy && (op_r == OP_WRITE);
    assign fl_page_o = page_r;
    assign fl_buf_data_o = buf_out_r;
    assign lock_bits_o = lock_bits_r;

endmodule

// >>> rtl/fsp_consts.vh
// Constants for the flash self-programming sequencer
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// Register offsets (8-bit address)
`define FSP_ADR_CMD 8'h00
`define FSP_ADR_PTR_LO 8'h01
`define FSP_ADR_PTR_HI 8'h02
`define FSP_ADR_DAT_LO 8'h03
`define FSP_ADR_DAT_HI 8'h04
`define FSP_ADR_STATUS 8'h05

// Command register fields
`define FSP_B_ENABLE 0
`define FSP_B_ERASE 1
`define FSP_B_WRITE 2
`define FSP_B_LOCK 3
`define FSP_B_REEN 4
`define FSP_B_BUSY 6
`define FSP_B_INTEN 7
`define FSP_CMD_RESET 8'h00

// Command codes (low five bits of the command register)
`define FSP_CODE_MASK 8'h1F
`define FSP_CODE_LOAD 8'h01
`define FSP_CODE_ERASE 8'h03
`define FSP_CODE_WRITE 8'h05
`define FSP_CODE_LOCK 8'h09
`define FSP_CODE_REEN 8'h11

// Pointer fields
`define FSP_PAGE_MSB 15
`define FSP_PAGE_LSB 6
`define FSP_WORD_MSB 5
`define FSP_WORD_LSB 1
`define FSP_BYTE_SEL 0

// Lock bits
`define FSP_LOCK_MSB 5
`define FSP_LOCK_RESET 6'h3F

// Sizes
`define FSP_BUF_WORDS 32
`define FSP_ERASED_WORD 16'hFFFF
`define FSP_APP_VECTOR 16'h0000

// Timing
`define FSP_CLK_PERIOD_NS 8
`define FSP_ARM_CYCLES 3'h4
`define FSP_PROG_TIME_NS 3200000

`endif

// >>> bench/fsp_monitor.sv
// Checker for the flash self-programming sequencer
`timescale 1ns/10ps
module fsp_monitor #(
    parameter [15:0] BOOT_VECTOR = 16'h3800,
    parameter [9:0] HALT_FIRST_PAGE = 10'h1C0,
    parameter integer PROG_CYCLES = 20
) (
    input wire clk_i, rst_i, wr_i, rd_i, store_i, eeprom_write_busy_i, boot_vector_fuse_i,
    input wire [7:0] addr_i, wdata_i, rdata_o,
    input wire [15:0] reset_vector_o,
    input wire irq_o, cpu_halt_o, fl_erase_o, fl_write_o, section_block_o,
    input wire [9:0] fl_page_o,
    input wire [5:0] lock_bits_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [2:0] set_r;
    integer prog_r;
    wire cmd_w = wr_i && addr_i == 8'h00;
    wire prog_w = fl_erase_o || fl_write_o;
    // Counts program cycles; the fuse sync needs a few edges after reset
    always @(posedge clk_i) begin
        set_r <= rst_i ? 3'h0 : (set_r == 3'h7 ? set_r : set_r + 3'h1);
        prog_r <= prog_w ? prog_r + 1 : 0;
    end
    AST_VEC_APP: assert property ((boot_vector_fuse_i) [*4] ##0 set_r == 3'h7 |-> reset_vector_o == 16'h0000)
        else $error("reset vector not application address");
    AST_VEC_BOOT: assert property ((!boot_vector_fuse_i) [*4] ##0 set_r == 3'h7 |-> reset_vector_o == BOOT_VECTOR)
        else $error("reset vector not boot address");
    AST_ERASE_GO: assert property (cmd_w && wdata_i[4:0] == 5'h03 && !eeprom_write_busy_i && !prog_w ##1 store_i
        |=> fl_erase_o && section_block_o) else $error("erase did not start");
    AST_PROG_LEN: assert property ($fell(fl_erase_o) || $fell(fl_write_o) |-> prog_r == PROG_CYCLES)
        else $error("program time wrong");
    AST_HALT: assert property ($rose(prog_w) |-> cpu_halt_o == (fl_page_o >= HALT_FIRST_PAGE))
        else $error("halt does not match section");
    AST_BLOCK: assert property (prog_w |-> section_block_o && !irq_o)
        else $error("section not blocked or irq during program");
    AST_BLOCK_STAYS: assert property (section_block_o && !(cmd_w && wdata_i[4:0] == 5'h11) |=> section_block_o)
        else $error("busy flag dropped without re-enable");
    AST_EE_NOPROG: assert property (eeprom_write_busy_i && cmd_w && !prog_w ##1 store_i |=> !prog_w)
        else $error("command taken during eeprom write");
    AST_LOCK_FREE: assert property (cmd_w && wdata_i[4:0] == 5'h09 && !section_block_o ##1 store_i
        |=> !section_block_o && !cpu_halt_o) else $error("lock setting blocked flash");
    AST_STATUS_EE: assert property (rd_i && addr_i == 8'h05 && eeprom_write_busy_i |=> rdata_o == 8'h00)
        else $error("status readable during eeprom write");
    COV_ERASE: cover property ($rose(fl_erase_o));
    COV_WRITE: cover property ($rose(fl_write_o));
    COV_LOCK: cover property (cmd_w && wdata_i[4:0] == 5'h09 ##1 store_i);
endmodule

// >>> bench/fsp_cpu_model.sv
// Behavioural CPU core driving the command port and instruction strobes
`timescale 1ns/10ps
module fsp_cpu_model (
    input wire clk_i,
    input wire [7:0] rdata_i,
    output reg [7:0] addr_o = 8'h00,
    output reg [7:0] wdata_o = 8'h00,
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0,
    output reg store_o = 1'b0,
    output reg load_o = 1'b0
);
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= 1'b1;
            @(posedge clk_i);
            wr_o <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            rd_o <= 1'b1;
            @(posedge clk_i);
            rd_o <= 1'b0;
            #1 d = rdata_i;
        end
    endtask
    // Store issued the cycle after the command write, well inside the window
    task spm(input [7:0] c);
        begin
            wr(8'h00, c);
            store_o <= 1'b1;
            @(posedge clk_i);
            store_o <= 1'b0;
        end
    endtask
    task ptr(input [15:0] p);
        begin
            wr(8'h01, p[7:0]);
            wr(8'h02, p[15:8]);
        end
    endtask
    task ld;
        begin
            @(posedge clk_i);
            load_o <= 1'b1;
            @(posedge clk_i);
            load_o <= 1'b0;
            #1;
        end
    endtask
endmodule

// >>> bench/test_fsp_ctrl.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
module test_fsp_ctrl;
    localparam integer PC = 20;
    localparam [15:0] BV = 16'h3800;
    reg clk_i = 1'b0, rst_i = 1'b1, ee = 1'b0, fuse = 1'b1;
    reg [4:0] idx = 5'h00;
    wire [7:0] addr, wdata, rdata, ldata;
    wire wr, rd, st, ld, halt, irq, fer, fwr, blk;
    wire [14:0] fra;
    wire [15:0] vec, bdat;
    wire [9:0] page;
    wire [5:0] lock;
    // Flash array stand-in: word derived from its address
    wire [15:0] frw = {1'b0, fra} ^ 16'h5A3C;
    integer n_errors = 0, checked = 0, seed = 796, i;
    reg [15:0] bufm [0:31];
    reg [5:0] lockm = 6'h3F;
    reg [7:0] r;
    reg [15:0] p, d;
    fsp_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .store_o(st), .load_o(ld));
    // Boot vector and halting section left at their defaults; BV mirrors the default vector
    fsp_ctrl #(.PROG_CYCLES(PC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .store_i(st), .load_i(ld),
        .load_data_o(ldata), .cpu_halt_o(halt), .irq_o(irq), .eeprom_write_busy_i(ee), .boot_vector_fuse_i(fuse),
        .reset_vector_o(vec), .fl_read_addr_o(fra), .fl_read_word_i(frw), .fl_erase_o(fer), .fl_write_o(fwr),
        .fl_page_o(page), .fl_buf_idx_i(idx), .fl_buf_data_o(bdat), .section_block_o(blk), .lock_bits_o(lock));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task chk(input [15:0] s, input [15:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chkbuf;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                @(posedge clk_i) idx <= k;
                @(posedge clk_i) #1 chk(bdat, bufm[k]);
            end
        end
    endtask
    task clrbuf;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1)
                bufm[k] = 16'hFFFF;
        end
    endtask
    // One load per slot: the hardware drops a repeat, so it is kept out of the model
    task ldw(input [15:0] a, input [15:0] v);
        begin
            cpu.ptr(a);
            cpu.wr(8'h03, v[7:0]);
            cpu.wr(8'h04, v[15:8]);
            cpu.spm(8'h01);
            if (bufm[a[5:1]] === 16'hFFFF)
                bufm[a[5:1]] = v;
        end
    endtask
    task idle;
        integer k;
        begin
            r = 8'h01;
            for (k = 0; k < 100 && r[0] === 1'b1; k = k + 1)
                cpu.rd(8'h00, r);
            chk(r[0], 1'b0);
        end
    endtask
    initial begin
        #200000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        clrbuf;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 chk(vec, 16'h0000);
        chk(lock, 6'h3F);
        @(posedge clk_i) fuse <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1 chk(vec, BV);
        cpu.wr(8'h40, 8'hA5);
        chk(vec, BV);
        $display("test vector done");
        for (i = 0; i < 4; i = i + 1)
            ldw({10'h1C5, i[4:0] * 5'h07, 1'b0}, $random(seed));
        ldw(16'h714E, 16'h1234);
        chkbuf;
        cpu.ptr(16'h7140);
        cpu.spm(8'h05);
        #1 chk({fwr, halt, blk}, 3'h7);
        cpu.ptr(16'h0000);
        chk(page, 10'h1C5);
        idle;
        clrbuf;
        chk(blk, 1'b1);
        chkbuf;
        cpu.wr(8'h00, 8'h11);
        #1 chk(blk, 1'b0);
        $display("test page write done");
        p = {10'h012, 6'h00} | ($random(seed) & 16'h003F);
        cpu.ptr(p);
        cpu.spm(8'h83);
        #1 chk({fer, halt, page}, {2'b10, 10'h012});
        idle;
        chk(irq, 1'b1);
        cpu.wr(8'h00, 8'h11);
        #1 chk({irq, blk}, 2'b00);
        cpu.wr(8'h00, 8'h03);
        repeat (5) @(posedge clk_i);
        cpu.rd(8'h00, r);
        chk({r[0], fer}, 2'b00);
        $display("test erase done");
        for (i = 0; i < 2; i = i + 1) begin
            d = {8'h00, 2'b11, 6'h00} | ($random(seed) & 16'h003F);
            // Second pass protects the boot code section for good
            if (i == 1) d[4] = 1'b0;
            cpu.ptr(i == 0 ? 16'h0001 : $random(seed));
            cpu.wr(8'h03, d[7:0]);
            cpu.spm(8'h09);
            #1 chk({blk, halt}, 2'b00);
            idle;
            lockm = lockm & d[5:0];
            chk(lock, lockm);
            cpu.rd(8'h05, r);
            chk(r, {2'b11, lockm});
        end
        $display("test lock done");
        // Eeprom stays idle before every other command write
        ldw(16'h0004, 16'hBEEF);
        @(posedge clk_i) ee <= 1'b1;
        cpu.rd(8'h05, r);
        chk(r, 8'h00);
        cpu.spm(8'h03);
        #1 chk(fer, 1'b0);
        @(posedge clk_i) ee <= 1'b0;
        clrbuf;
        chkbuf;
        $display("test eeprom done");
        for (i = 0; i < 3; i = i + 1) begin
            p = $random(seed);
            cpu.ptr(p);
            #1 chk(fra, p[15:1]);
            cpu.ld;
            d = {1'b0, p[15:1]} ^ 16'h5A3C;
            chk(ldata, p[0] ? d[15:8] : d[7:0]);
        end
        $display("test load done");
        // Fuse back to unprogrammed: vector must return to the application
        @(posedge clk_i) fuse <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1 chk(vec, 16'h0000);
        $display("test vector return done");
        report_and_stop;
    end
endmodule
bind fsp_ctrl fsp_monitor #(.PROG_CYCLES(PROG_CYCLES))
    u_mon (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .store_i(store_i),
    .eeprom_write_busy_i(eeprom_write_busy_i), .boot_vector_fuse_i(boot_vector_fuse_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .reset_vector_o(reset_vector_o), .irq_o(irq_o), .cpu_halt_o(cpu_halt_o),
    .fl_erase_o(fl_erase_o), .fl_write_o(fl_write_o), .section_block_o(section_block_o), .fl_page_o(fl_page_o),
    .lock_bits_o(lock_bits_o));
